// ==== hdl/tfr_register_bank.sv ====
// Register bank of the remote-diode temperature sensor with fan control
`timescale 1ns/1ps

module tfr_register_bank #(
  parameter logic [7:0] MAKER_ID = 8'h5A,  // Arbitrary value
  parameter logic [7:0] REVISION_ID = 8'h23  // Arbitrary value
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register access from the serial slave engine
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Measured state from the conversion and fan logic
  input wire logic [7:0] local_temp_in,
  input wire logic [7:0] remote_temp_high_in,
  input wire logic [7:0] remote_temp_low_in,
  input wire logic [7:0] alert_flags_in,
  input wire logic [15:0] fan_count_in,
  input wire logic [5:0] duty_auto_in,
  // Lookup table read port for the fan logic
  input wire logic [3:0] lut_index,
  output logic [7:0] lut_entry,
  // Configuration towards the conversion and alert logic
  output logic [7:0] config_out,
  output logic [7:0] conversion_rate_out,
  output logic [7:0] local_high_limit_out,
  output logic [7:0] remote_high_limit_high_out,
  output logic [7:0] remote_low_limit_high_out,
  output logic [7:0] remote_offset_high_out,
  output logic [7:0] remote_offset_low_out,
  output logic [7:0] remote_high_limit_low_out,
  output logic [7:0] remote_low_limit_low_out,
  output logic [7:0] alert_source_mask_out,
  output logic [7:0] remote_critical_limit_out,
  output logic [7:0] remote_critical_hyst_out,
  output logic [7:0] remote_filter_out,
  output logic single_conversion_pulse,
  // Configuration towards the fan logic
  output logic [7:0] fan_period_limit_low_out,
  output logic [7:0] fan_period_limit_high_out,
  output logic [7:0] fan_drive_config_out,
  output logic [7:0] fan_startup_config_out,
  output logic [7:0] fan_drive_frequency_out,
  output logic [7:0] duty_table_hyst_out,
  output logic [5:0] duty_out,
  output logic duty_override_enable
);

  // ==========================================================
  // Address decode
  logic [7:0] rw_reg [0:tfr_pkg::RW_COUNT-1];
  logic [tfr_pkg::RW_COUNT-1:0] rw_hit;
  logic [7:0] lut_reg [0:tfr_pkg::LUT_DEPTH-1];
  logic [5:0] duty_reg;
  logic [5:0] duty_next;
  logic [7:0] rdata_next;
  logic override_on;
  logic duty_hit;
  logic lut_hit;
  logic one_shot_hit;
  logic [3:0] lut_waddr;
  logic lut_wr;
  logic one_shot_reg;
  logic [7:0] lut_entry_reg;
  logic [7:0] rdata_reg;
  logic rvalid_reg;

  assign override_on = rw_reg[tfr_pkg::IDX_DRIVE_CFG][tfr_pkg::DUTY_OVERRIDE_BIT];
  assign duty_hit = (reg_addr == tfr_pkg::OFS_FAN_DUTY_VALUE);
  assign lut_hit = (reg_addr >= tfr_pkg::OFS_DUTY_TABLE_BASE) &&
                   (reg_addr <= tfr_pkg::OFS_DUTY_TABLE_LAST);
  assign one_shot_hit = (reg_addr == tfr_pkg::OFS_SINGLE_CONVERSION);
  assign lut_waddr = reg_addr[3:0];
  assign lut_wr = reg_wr && lut_hit && override_on;

  // ==========================================================
  // Plain read/write registers, one storage element per register
  genvar gi;
  generate
    for (gi = 0; gi < tfr_pkg::RW_COUNT; gi = gi + 1)
    begin : g_rw
      assign rw_hit[gi] = (reg_addr == tfr_pkg::RW_OFFSET[gi]) ||
                          (reg_addr == tfr_pkg::RW_MIRROR[gi]);
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
          rw_reg[gi] <= tfr_pkg::RW_RESET[gi];
        else if (reg_wr && rw_hit[gi])
          rw_reg[gi] <= (reg_wdata & tfr_pkg::RW_MASK[gi]) | tfr_pkg::RW_ONES[gi];
      end
    end
  endgenerate

  // ==========================================================
  // Lookup table, writable only under override
  generate
    for (gi = 0; gi < tfr_pkg::LUT_DEPTH; gi = gi + 1)
    begin : g_lut
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
          lut_reg[gi] <= tfr_pkg::LUT_RESET;
        else if (lut_wr && (lut_waddr == 4'(gi)))
          lut_reg[gi] <= reg_wdata;
      end
    end
  endgenerate

  // ==========================================================
  // Duty value: follows the fan logic, or the host under override
  always_comb
  begin
    duty_next = duty_reg;
    if (!override_on)
      duty_next = duty_auto_in;
    else if (reg_wr && duty_hit)
      duty_next = reg_wdata[tfr_pkg::DUTY_W-1:0];
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      duty_reg <= tfr_pkg::DUTY_RESET;
    else
      duty_reg <= duty_next;
  end

  // ==========================================================
  // Read data selection; unused and write-only locations read zero
  always_comb
  begin
    rdata_next = tfr_pkg::READ_ZERO;
    for (int i = 0; i < tfr_pkg::RW_COUNT; i++)
    begin
      if (rw_hit[i])
        rdata_next = rw_reg[i];
    end
    if (reg_addr == tfr_pkg::OFS_LOCAL_TEMPERATURE)
      rdata_next = local_temp_in;
    else if (reg_addr == tfr_pkg::OFS_REMOTE_TEMP_HIGH)
      rdata_next = remote_temp_high_in;
    else if (reg_addr == tfr_pkg::OFS_ALERT_FLAGS)
      rdata_next = alert_flags_in;
    else if (reg_addr == tfr_pkg::OFS_REMOTE_TEMP_LOW)
      rdata_next = remote_temp_low_in & tfr_pkg::REMOTE_LOW_MASK;
    else if (reg_addr == tfr_pkg::OFS_FAN_COUNT_LOW)
      rdata_next = fan_count_in[7:0];
    else if (reg_addr == tfr_pkg::OFS_FAN_COUNT_HIGH)
      rdata_next = fan_count_in[15:8];
    else if (duty_hit)
      rdata_next = {2'b00, duty_reg};
    else if (lut_hit)
      rdata_next = lut_reg[lut_waddr];
    else if (reg_addr == tfr_pkg::OFS_MAKER_IDENTIFIER)
      rdata_next = MAKER_ID;
    else if (reg_addr == tfr_pkg::OFS_SILICON_REVISION)
      rdata_next = REVISION_ID;
  end

  // ==========================================================
  // Registered read answer, one-shot pulse and table read port
  // Read-only and unused locations have no write path at all
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_reg <= tfr_pkg::READ_ZERO;
      rvalid_reg <= 1'b0;
      one_shot_reg <= 1'b0;
      lut_entry_reg <= tfr_pkg::LUT_RESET;
    end
    else
    begin
      rvalid_reg <= reg_rd;
      if (reg_rd)
        rdata_reg <= rdata_next;
      one_shot_reg <= reg_wr && one_shot_hit;
      lut_entry_reg <= lut_reg[lut_index];
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign single_conversion_pulse = one_shot_reg;
  assign lut_entry = lut_entry_reg;
  assign duty_out = duty_reg;
  assign duty_override_enable = override_on;
  assign config_out = rw_reg[tfr_pkg::IDX_CONFIG];
  assign conversion_rate_out = rw_reg[1];
  assign local_high_limit_out = rw_reg[2];
  assign remote_high_limit_high_out = rw_reg[3];
  assign remote_low_limit_high_out = rw_reg[4];
  assign remote_offset_high_out = rw_reg[5];
  assign remote_offset_low_out = rw_reg[6];
  assign remote_high_limit_low_out = rw_reg[7];
  assign remote_low_limit_low_out = rw_reg[8];
  assign alert_source_mask_out = rw_reg[9];
  assign remote_critical_limit_out = rw_reg[10];
  assign remote_critical_hyst_out = rw_reg[11];
  assign fan_period_limit_low_out = rw_reg[12];
  assign fan_period_limit_high_out = rw_reg[13];
  assign fan_drive_config_out = rw_reg[tfr_pkg::IDX_DRIVE_CFG];
  assign fan_startup_config_out = rw_reg[15];
  assign fan_drive_frequency_out = rw_reg[16];
  assign duty_table_hyst_out = rw_reg[17];
  assign remote_filter_out = rw_reg[18];

endmodule // tfr_register_bank

// ==== hdl/tfr_pkg.sv ====
// Package of register offsets, masks and reset values for the thermal fan register bank
package tfr_pkg;

  // ==========================================================
  // Register widths and table size
  localparam int DATA_W = 8;
  localparam int RW_COUNT = 19;
  localparam int LUT_DEPTH = 16;

  // ==========================================================
  // Plain read/write registers: index into the tables below
  localparam int IDX_CONFIG = 0;
  localparam int IDX_DRIVE_CFG = 14;

  // Primary offset, mirror offset (equal to primary where none), writable bits,
  // bits that always read as one, and reset value
  localparam logic [7:0] RW_OFFSET [0:RW_COUNT-1] = '{
    8'h03, 8'h04, 8'h05, 8'h07, 8'h08, 8'h11, 8'h12, 8'h13, 8'h14, 8'h16,
    8'h19, 8'h21, 8'h48, 8'h49, 8'h4A, 8'h4B, 8'h4D, 8'h4F, 8'hBF};
  localparam logic [7:0] RW_MIRROR [0:RW_COUNT-1] = '{
    8'h09, 8'h0A, 8'h0B, 8'h0D, 8'h0E, 8'h11, 8'h12, 8'h13, 8'h14, 8'h16,
    8'h19, 8'h21, 8'h48, 8'h49, 8'h4A, 8'h4B, 8'h4D, 8'h4F, 8'hBF};
  localparam logic [7:0] RW_MASK [0:RW_COUNT-1] = '{
    8'hE7, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hE0, 8'hE0, 8'hE0, 8'h5B,
    8'hFF, 8'hFF, 8'hFC, 8'hFF, 8'h3B, 8'h3F, 8'h1F, 8'h1F, 8'h07};
  localparam logic [7:0] RW_ONES [0:RW_COUNT-1] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hA4,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] RW_RESET [0:RW_COUNT-1] = '{
    8'h00, 8'h08, 8'h46, 8'h46, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hA4,
    8'h55, 8'h0A, 8'hFF, 8'hFF, 8'h20, 8'h3F, 8'h17, 8'h04, 8'h00};

  // ==========================================================
  // Special locations
  localparam logic [7:0] OFS_LOCAL_TEMPERATURE = 8'h00;
  localparam logic [7:0] OFS_REMOTE_TEMP_HIGH = 8'h01;
  localparam logic [7:0] OFS_ALERT_FLAGS = 8'h02;
  localparam logic [7:0] OFS_SINGLE_CONVERSION = 8'h0F;
  localparam logic [7:0] OFS_REMOTE_TEMP_LOW = 8'h10;
  localparam logic [7:0] OFS_FAN_COUNT_LOW = 8'h46;
  localparam logic [7:0] OFS_FAN_COUNT_HIGH = 8'h47;
  localparam logic [7:0] OFS_FAN_DUTY_VALUE = 8'h4C;
  localparam logic [7:0] OFS_DUTY_TABLE_BASE = 8'h50;
  localparam logic [7:0] OFS_DUTY_TABLE_LAST = 8'h5F;
  localparam logic [7:0] OFS_MAKER_IDENTIFIER = 8'hFE;
  localparam logic [7:0] OFS_SILICON_REVISION = 8'hFF;

  // ==========================================================
  // Fields and reset values
  localparam int DUTY_OVERRIDE_BIT = 5;
  localparam int DUTY_W = 6;
  localparam logic [7:0] REMOTE_LOW_MASK = 8'hE0;
  localparam logic [5:0] DUTY_RESET = 6'h00;
  localparam logic [7:0] LUT_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

endpackage

// ==== bench/tfr_register_bank_asserts.sv ====
// Port assertions for the thermal fan register bank
`timescale 1ns/1ps
module tfr_register_bank_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Observed state
  input wire logic [7:0] local_temp_in,
  input wire logic [5:0] duty_auto_in,
  input wire logic [7:0] config_out,
  input wire logic [7:0] conversion_rate_out,
  input wire logic [5:0] duty_out,
  input wire logic duty_override_enable
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Checks
  a_cfg_mirror_write: assert property (
    reg_wr && reg_addr == 8'h09 |=> config_out == ($past(reg_wdata) & 8'hE7))
    else $error("config mirror write lost");
  a_rate_alias_write: assert property (
    reg_wr && reg_addr == 8'h0A |=> conversion_rate_out == ($past(reg_wdata) & 8'h0F))
    else $error("rate mirror write lost");
  a_duty_write_locked: assert property (
    reg_wr && reg_addr == 8'h4C && !duty_override_enable |=> duty_out == $past(duty_auto_in))
    else $error("duty written while locked");
  a_duty_override_write: assert property (
    reg_wr && reg_addr == 8'h4C && duty_override_enable
    |=> {2'b00, duty_out} == ($past(reg_wdata) & 8'h3F))
    else $error("duty override write lost");
  a_duty_override_hold: assert property (
    duty_override_enable && !(reg_wr && reg_addr == 8'h4C) |=> $stable(duty_out))
    else $error("duty moved under override");
  a_unused_read_zero: assert property (
    reg_rd && (reg_addr inside {[8'h60:8'hBE], [8'hC0:8'hFD]}) |=> reg_rdata == 8'h00)
    else $error("unused place read nonzero");
  a_ro_read_live: assert property (
    reg_rd && reg_addr == 8'h00 |=> reg_rdata == $past(local_temp_in))
    else $error("local temperature read wrong");
  c_override_write: cover property (reg_wr && reg_addr == 8'h4C && duty_override_enable);
  c_mirror_read: cover property (reg_rd && reg_addr == 8'h0B);
  c_unused_write: cover property (reg_wr && reg_addr == 8'hBE);
endmodule // tfr_register_bank_asserts

// ==== bench/tfr_host_model.sv ====
// Host controller model issuing register reads and writes
`timescale 1ns/1ps
module tfr_host_model (
  // Clock
  input wire logic mclk,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Idle address shows the inverse of the last address; idle data shows the inverse of the last write data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge mclk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask
endmodule // tfr_host_model

// ==== bench/tfr_register_bank_test.sv ====
// Self-checking testbench of the thermal fan register bank
`timescale 1ns/1ps
module tfr_register_bank_test;
  // ==========================================================
  // Signals
  localparam logic [7:0] MAKER = 8'h3C;  // Arbitrary value
  localparam logic [7:0] REV = 8'h9D;  // Arbitrary value
  logic mclk, rst_n, reg_wr, reg_rd, reg_rvalid, single_conversion_pulse, duty_override_enable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, lut_entry, rd_val;
  logic [7:0] local_temp_in, remote_temp_high_in, remote_temp_low_in, alert_flags_in;
  logic [15:0] fan_count_in;
  logic [5:0] duty_auto_in, duty_out;
  logic [3:0] lut_index;
  logic [7:0] config_out, conversion_rate_out, local_high_limit_out, remote_high_limit_high_out;
  logic [7:0] remote_low_limit_high_out, remote_offset_high_out, remote_offset_low_out;
  logic [7:0] remote_high_limit_low_out, remote_low_limit_low_out, alert_source_mask_out;
  logic [7:0] remote_critical_limit_out, remote_critical_hyst_out, remote_filter_out;
  logic [7:0] fan_period_limit_low_out, fan_period_limit_high_out, fan_drive_config_out;
  logic [7:0] fan_startup_config_out, fan_drive_frequency_out, duty_table_hyst_out;
  logic [7:0] ro_addr [0:7], ro_exp [0:7], un_addr [0:5];
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  tfr_register_bank #(.MAKER_ID(MAKER), .REVISION_ID(REV)) uut (.*);
  tfr_host_model host (.mclk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid);
  // ==========================================================
  // Clock, timeout and reporting
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      error_cnt = error_cnt + 1;
      conclude();
    end
  end
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rd_val);
    chk(e, rd_val);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial
  begin
    rst_n = 1'b0;
    local_temp_in = 8'h3B;
    remote_temp_high_in = 8'h51;
    remote_temp_low_in = 8'hFF;
    alert_flags_in = 8'h96;
    fan_count_in = 16'h12C7;
    duty_auto_in = 6'h2D;
    lut_index = 4'hF;
    ro_addr = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h46, 8'h47, 8'hFE, 8'hFF};
    ro_exp = '{8'h3B, 8'h51, 8'h96, 8'hE0, 8'hC7, 8'h12, MAKER, REV};
    un_addr = '{8'h06, 8'h60, 8'hBE, 8'hC0, 8'hFD, 8'h0F};
    repeat (8) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < tfr_pkg::RW_COUNT; i++)
    begin
      rchk(tfr_pkg::RW_OFFSET[i], tfr_pkg::RW_RESET[i]);
      rchk(tfr_pkg::RW_MIRROR[i], tfr_pkg::RW_RESET[i]);
    end
    host.wr(8'h4C, 8'hEA);
    chk(8'h2A, {2'b00, duty_out});
    rchk(8'h4C, 8'h2A);
    host.wr(8'h5F, 8'h5C);
    @(posedge mclk);
    #1;
    chk(8'h5C, lut_entry);
    for (int i = 0; i < tfr_pkg::RW_COUNT; i++)
      host.wr(tfr_pkg::RW_MIRROR[i < 4 ? i + 14 : (i < 18 ? i - 4 : 18)], 8'hFF);
    for (int i = 0; i < tfr_pkg::RW_COUNT; i++)
      rchk(tfr_pkg::RW_OFFSET[i], tfr_pkg::RW_MASK[i] | tfr_pkg::RW_ONES[i]);
    host.wr(8'h4A, 8'h00);
    host.wr(8'h4C, 8'h3F);
    rchk(8'h4C, {2'b00, duty_auto_in});
    host.wr(8'h5F, 8'h11);
    @(posedge mclk);
    #1;
    chk(8'h5C, lut_entry);
    host.wr(8'h0F, 8'h01);
    chk(8'h01, {7'b000_0000, single_conversion_pulse});
    @(posedge mclk);
    #1;
    chk(8'h00, {7'b000_0000, single_conversion_pulse});
    foreach (ro_addr[i])
    begin
      host.wr(ro_addr[i], 8'hA5);
      rchk(ro_addr[i], ro_exp[i]);
    end
    foreach (un_addr[i])
    begin
      host.wr(un_addr[i], 8'hFF);
      rchk(un_addr[i], 8'h00);
    end
    rchk(8'h03, 8'hE7);
    conclude();
  end
endmodule // tfr_register_bank_test
bind tfr_register_bank tfr_register_bank_asserts chk_i (.mclk, .rst_n, .reg_addr, .reg_wr,
  .reg_wdata, .reg_rd, .reg_rdata, .local_temp_in, .duty_auto_in, .config_out,
  .conversion_rate_out, .duty_out, .duty_override_enable);
